// >>> cmrp_defs.svh
`ifndef CMRP_DEFS_SVH
`define CMRP_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define CMRP_ADR_BUSSF   16'h081D
`define CMRP_ADR_GSTAT   16'h2904
`define CMRP_ADR_CMD     16'h2905
`define CMRP_ADR_SEL     16'h2906
`define CMRP_ADR_FCNT    16'h2907
`define CMRP_ADR_FOUT    16'h2908
`define CMRP_ADR_MASK    16'h290A
`define CMRP_ADR_CODE    16'h290B
`define CMRP_ADR_BSTAT   16'h290E
`define CMRP_ADR_DIR     16'h290F
`define CMRP_ADR_ID      16'h2910
`define CMRP_ADR_BCNT    16'h2911
`define CMRP_ADR_DATA0   16'h2912
`define CMRP_ADR_DATA7   16'h2919

////////////////////////////////////////////////////////////////////////////////
// Command codes
`define CMRP_CMD_ACT     32'h00000001
`define CMRP_CMD_DEACT   32'h00000002
`define CMRP_CMD_CLRNEW  32'h00000004
`define CMRP_CMD_CLROVR  32'h00000005
`define CMRP_CMD_CLRFIFO 32'h00000007
`define CMRP_CMD_ID11    32'h00000008
`define CMRP_CMD_ID29    32'h00000009

////////////////////////////////////////////////////////////////////////////////
// Field positions and values
`define CMRP_BSF_PRIM    2
`define CMRP_BSF_ONLY    3
`define CMRP_GST_NEW     1
`define CMRP_GST_IDLEN   2
`define CMRP_BST_ACT     0
`define CMRP_BST_NEW     1
`define CMRP_BST_OVR     2
`define CMRP_FIFO_EMPTY  32'hFFFFFFFF
`define CMRP_ID11_MASK   29'h000007FF
`define CMRP_ID29_MASK   29'h1FFFFFFF
`define CMRP_RST_BUSSF   32'h00000000

`endif

// >>> cmrp_pkg.sv
package cmrp_pkg;

  typedef logic [28:0] cmrp_id_t;
  typedef logic [3:0]  cmrp_bcnt_t;
  typedef logic [63:0] cmrp_data_t;

  typedef enum logic {
    CMRP_ID11,
    CMRP_ID29
  } cmrp_idlen_t;

endpackage

// >>> cmrp_mailbox_rx.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`include "cmrp_defs.svh"

// Operation
// - Command 1 activates the selected box and sets its status bit 0.
// - Global status bit 1 is set while any box holds unacknowledged data.
// - Box status bit 2 reports overrun of unacknowledged data.
// - Selected box shows byte count and data bytes 0 to 7.
// - Command 4 acknowledges a message and makes the box ready again.
// - Accept frames valid, passing the mask, matching an active receive box.
// - Accepted frame sets new flag, or sets overrun and drops data if set.
// - Stored frame increments FIFO count and enqueues the box number; a full FIFO drops the number unless read or cleared that cycle.
// - After enqueue the global new-message flag is set.
// - Bus function bit 2 enables mailboxes at next start-up, expansions allowed.
// - Bus function bit 3 enables only mailboxes at next start-up.
// - Global status bit 2 shows identifier length, 0 is 11, 1 is 29 bits.
// - Global status is read only; writes change nothing.
// - Reading the FIFO output pops it; empty reads minus one.
// - Selection accepts mailbox numbers 0 through 31.
// - Command 4 clears box bit 1, command 5 clears box bit 2.
module cmrp_mailbox_rx #(
  parameter int NUM_BOX    = 32,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic [15:0]          regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWrEn,
  input  wire logic                 regRdEn,
  output logic [31:0]               regRdData,
  input  wire logic                 rxFrameValid,
  input  wire cmrp_pkg::cmrp_id_t   rxId,
  input  wire logic                 rxExtended,
  input  wire cmrp_pkg::cmrp_bcnt_t rxByteCount,
  input  wire cmrp_pkg::cmrp_data_t rxData,
  input  wire logic                 busStartup,
  output logic                      primEnabled,
  output logic                      expansionEnabled,
  output logic                      globalNewMessage
);
  import cmrp_pkg::*;

  localparam int BW = $clog2(NUM_BOX);
  localparam int FW = $clog2(FIFO_DEPTH);
  localparam logic [FW:0] FIFO_FULL = (FW+1)'(FIFO_DEPTH);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0]        busSpecial_ff;
  logic [BW-1:0]      selBox_ff;
  cmrp_idlen_t        idLen_ff;
  cmrp_id_t           rxMask_ff;
  cmrp_id_t           rxCode_ff;
  logic               primEn_ff;
  logic               expEn_ff;
  logic               globalNew_ff;
  logic [31:0]        rdData_ff;
  logic [31:0]        rdMux;

  logic [NUM_BOX-1:0] boxAct_ff;
  logic [NUM_BOX-1:0] boxDir_ff;
  logic [NUM_BOX-1:0] boxNew_ff;
  logic [NUM_BOX-1:0] boxOvr_ff;
  cmrp_id_t           boxId_ff   [NUM_BOX];
  cmrp_bcnt_t         boxCnt_ff  [NUM_BOX];
  cmrp_data_t         boxData_ff [NUM_BOX];

  logic [BW-1:0]      fifoMem_ff [FIFO_DEPTH];
  logic [FW-1:0]      wrPtr_ff;
  logic [FW-1:0]      rdPtr_ff;
  logic [FW:0]        fifoCnt_ff;

  logic               cmdWr;
  logic               cmdAct;
  logic               cmdDeact;
  logic               cmdClrNew;
  logic               cmdClrOvr;
  logic               cmdClrFifo;
  logic               cmdId11;
  logic               cmdId29;
  logic               dataWr;
  logic [2:0]         dataIdx;
  cmrp_id_t           idWidth;
  logic               maskPass;
  logic               frameOk;
  logic [NUM_BOX-1:0] boxMatch;
  logic [NUM_BOX-1:0] boxHit;
  logic [NUM_BOX-1:0] boxSel;
  logic               hit;
  logic [BW-1:0]      hitBox;
  logic               hitStored;
  logic               push;
  logic               pop;
  logic [FW-1:0]      pushPtr;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  assign cmdWr      = regWrEn && (regAddr == `CMRP_ADR_CMD);
  assign cmdAct     = cmdWr && (regWrData == `CMRP_CMD_ACT);
  assign cmdDeact   = cmdWr && (regWrData == `CMRP_CMD_DEACT);
  assign cmdClrNew  = cmdWr && (regWrData == `CMRP_CMD_CLRNEW);
  assign cmdClrOvr  = cmdWr && (regWrData == `CMRP_CMD_CLROVR);
  assign cmdClrFifo = cmdWr && (regWrData == `CMRP_CMD_CLRFIFO);
  assign cmdId11    = cmdWr && (regWrData == `CMRP_CMD_ID11);
  assign cmdId29    = cmdWr && (regWrData == `CMRP_CMD_ID29);
  assign dataWr     = regWrEn && (regAddr >= `CMRP_ADR_DATA0) && (regAddr <= `CMRP_ADR_DATA7);
  assign dataIdx    = 3'(regAddr - `CMRP_ADR_DATA0);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame filtering
  assign idWidth  = (idLen_ff == CMRP_ID29) ? `CMRP_ID29_MASK : `CMRP_ID11_MASK;
  assign maskPass = (((rxId ^ rxCode_ff) & rxMask_ff & idWidth) == '0);
  // Frames of the other identifier format are ignored rather than truncated
  assign frameOk  = rxFrameValid && primEn_ff && maskPass
                    && (rxExtended == (idLen_ff == CMRP_ID29));

  // Lowest-numbered matching box wins when identifiers overlap
  always_comb begin
    hit    = 1'b0;
    hitBox = '0;
    for (int i = NUM_BOX - 1; i >= 0; i--) begin
      if (boxMatch[i]) begin
        hit    = 1'b1;
        hitBox = BW'(i);
      end
    end
  end

  // A clear in the same cycle frees the box, so the frame is stored, not lost
  assign hitStored = hit && !(boxNew_ff[hitBox] && !(cmdClrNew && boxSel[hitBox]));

  ////////////////////////////////////////////////////////////////////////////////
  // Mailbox storage
  genvar g;
  generate
    for (g = 0; g < NUM_BOX; g++) begin : gBox
      logic newEff;

      assign boxSel[g]   = (selBox_ff == BW'(g));
      assign boxMatch[g] = frameOk && boxAct_ff[g] && !boxDir_ff[g]
                           && (((rxId ^ boxId_ff[g]) & idWidth) == '0);
      assign boxHit[g]   = hit && (hitBox == BW'(g));
      assign newEff      = boxNew_ff[g] && !(cmdClrNew && boxSel[g]);

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          boxAct_ff[g] <= 1'b0;
        end else if (cmdAct && boxSel[g]) begin
          boxAct_ff[g] <= 1'b1;
        end else if (cmdDeact && boxSel[g]) begin
          boxAct_ff[g] <= 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          boxDir_ff[g] <= 1'b0;
          boxId_ff[g]  <= '0;
        end else if (regWrEn && boxSel[g]) begin
          if (regAddr == `CMRP_ADR_DIR) begin
            boxDir_ff[g] <= regWrData[0];
          end
          if (regAddr == `CMRP_ADR_ID) begin
            boxId_ff[g] <= regWrData[28:0];
          end
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          boxNew_ff[g]  <= 1'b0;
          boxCnt_ff[g]  <= '0;
          boxData_ff[g] <= '0;
        end else if (boxHit[g] && !newEff) begin
          boxNew_ff[g]  <= 1'b1;
          boxCnt_ff[g]  <= rxByteCount;
          boxData_ff[g] <= rxData;
        end else begin
          if (cmdClrNew && boxSel[g]) begin
            boxNew_ff[g] <= 1'b0;
          end
          if (regWrEn && boxSel[g] && (regAddr == `CMRP_ADR_BCNT)) begin
            boxCnt_ff[g] <= regWrData[3:0];
          end
          if (dataWr && boxSel[g]) begin
            boxData_ff[g][{dataIdx, 3'b000} +: 8] <= regWrData[7:0];
          end
        end
      end

      // Overrun set beats a simultaneous clear
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          boxOvr_ff[g] <= 1'b0;
        end else if (boxHit[g] && newEff) begin
          boxOvr_ff[g] <= 1'b1;
        end else if (cmdClrOvr && boxSel[g]) begin
          boxOvr_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Notification FIFO
  assign pop     = regRdEn && (regAddr == `CMRP_ADR_FOUT) && (fifoCnt_ff != '0);
  // Full only if acks outpace FIFO reads; the extra entry is then dropped
  assign push    = hitStored && ((fifoCnt_ff != FIFO_FULL) || pop || cmdClrFifo);
  assign pushPtr = cmdClrFifo ? '0 : wrPtr_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      fifoMem_ff[pushPtr] <= hitBox;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPtr_ff <= '0;
    end else if (push) begin
      wrPtr_ff <= FW'(pushPtr + 1'b1);
    end else if (cmdClrFifo) begin
      wrPtr_ff <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdPtr_ff <= '0;
    end else if (cmdClrFifo) begin
      rdPtr_ff <= '0;
    end else if (pop) begin
      rdPtr_ff <= FW'(rdPtr_ff + 1'b1);
    end
  end

  // A push in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fifoCnt_ff <= '0;
    end else if (cmdClrFifo) begin
      fifoCnt_ff <= push ? (FW+1)'(1) : '0;
    end else if (push && !pop) begin
      fifoCnt_ff <= (FW+1)'(fifoCnt_ff + 1'b1);
    end else if (pop && !push) begin
      fifoCnt_ff <= (FW+1)'(fifoCnt_ff - 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Global configuration and status
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busSpecial_ff <= `CMRP_RST_BUSSF;
    end else if (regWrEn && (regAddr == `CMRP_ADR_BUSSF)) begin
      busSpecial_ff <= regWrData;
    end
  end

  // Enables only change at bus start-up, never mid-traffic
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      primEn_ff <= 1'b0;
      expEn_ff  <= 1'b1;
    end else if (busStartup) begin
      primEn_ff <= busSpecial_ff[`CMRP_BSF_PRIM] | busSpecial_ff[`CMRP_BSF_ONLY];
      expEn_ff  <= !busSpecial_ff[`CMRP_BSF_ONLY];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      selBox_ff <= '0;
    end else if (regWrEn && (regAddr == `CMRP_ADR_SEL)) begin
      selBox_ff <= regWrData[BW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      idLen_ff <= CMRP_ID11;
    end else if (cmdId11) begin
      idLen_ff <= CMRP_ID11;
    end else if (cmdId29) begin
      idLen_ff <= CMRP_ID29;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxMask_ff <= '0;
      rxCode_ff <= '0;
    end else if (cmdId11 || cmdId29) begin
      rxMask_ff <= '0;
      rxCode_ff <= '0;
    end else begin
      if (regWrEn && (regAddr == `CMRP_ADR_MASK)) begin
        rxMask_ff <= regWrData[28:0];
      end
      if (regWrEn && (regAddr == `CMRP_ADR_CODE)) begin
        rxCode_ff <= regWrData[28:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      globalNew_ff <= 1'b0;
    end else begin
      globalNew_ff <= |boxNew_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    rdMux = '0;
    if (regAddr == `CMRP_ADR_BUSSF) begin
      rdMux = busSpecial_ff;
    end else if (regAddr == `CMRP_ADR_GSTAT) begin
      rdMux[`CMRP_GST_NEW]   = globalNew_ff;
      rdMux[`CMRP_GST_IDLEN] = (idLen_ff == CMRP_ID29);
    end else if (regAddr == `CMRP_ADR_SEL) begin
      rdMux = 32'(selBox_ff);
    end else if (regAddr == `CMRP_ADR_FCNT) begin
      rdMux = 32'(fifoCnt_ff);
    end else if (regAddr == `CMRP_ADR_FOUT) begin
      rdMux = (fifoCnt_ff == '0) ? `CMRP_FIFO_EMPTY : 32'(fifoMem_ff[rdPtr_ff]);
    end else if (regAddr == `CMRP_ADR_MASK) begin
      rdMux = 32'(rxMask_ff);
    end else if (regAddr == `CMRP_ADR_CODE) begin
      rdMux = 32'(rxCode_ff);
    end else if (regAddr == `CMRP_ADR_BSTAT) begin
      rdMux[`CMRP_BST_ACT] = boxAct_ff[selBox_ff];
      rdMux[`CMRP_BST_NEW] = boxNew_ff[selBox_ff];
      rdMux[`CMRP_BST_OVR] = boxOvr_ff[selBox_ff];
    end else if (regAddr == `CMRP_ADR_DIR) begin
      rdMux = 32'(boxDir_ff[selBox_ff]);
    end else if (regAddr == `CMRP_ADR_ID) begin
      rdMux = 32'(boxId_ff[selBox_ff]);
    end else if (regAddr == `CMRP_ADR_BCNT) begin
      rdMux = 32'(boxCnt_ff[selBox_ff]);
    end else if ((regAddr >= `CMRP_ADR_DATA0) && (regAddr <= `CMRP_ADR_DATA7)) begin
      rdMux = 32'(boxData_ff[selBox_ff][{dataIdx, 3'b000} +: 8]);
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdData_ff <= '0;
    end else if (regRdEn) begin
      rdData_ff <= rdMux;
    end else begin
      rdData_ff <= '0;
    end
  end

  assign regRdData        = rdData_ff;
  assign primEnabled      = primEn_ff;
  assign expansionEnabled = expEn_ff;
  assign globalNewMessage = globalNew_ff;

endmodule

// >>> cmrp_mailbox_rx_asserts.sv
`timescale 1ns/10ps
`include "cmrp_defs.svh"
module cmrp_mailbox_rx_asserts #(
  parameter int NUM_BOX    = 32,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic [15:0]          regAddr,
  input wire logic [31:0]          regWrData,
  input wire logic                 regWrEn,
  input wire logic                 regRdEn,
  input wire logic [31:0]          regRdData,
  input wire logic                 rxFrameValid,
  input wire cmrp_pkg::cmrp_id_t   rxId,
  input wire logic                 rxExtended,
  input wire cmrp_pkg::cmrp_bcnt_t rxByteCount,
  input wire cmrp_pkg::cmrp_data_t rxData,
  input wire logic                 busStartup,
  input wire logic                 primEnabled,
  input wire logic                 expansionEnabled,
  input wire logic                 globalNewMessage
);
  import cmrp_pkg::*;
  logic [31:0] busSf_ff;
  logic        idLong_ff;
  logic        rdPend_ff;
  logic [15:0] rdAddr_ff;
  wire         wrCmd     = regWrEn && regAddr == `CMRP_ADR_CMD;
  wire         frameSeen = rxFrameValid && primEnabled;
  ////////////////////////////////////////
  // Shadows of bus function and id length, as software wrote them
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busSf_ff <= '0;
      idLong_ff <= 1'h0;
    end else begin
      if (regWrEn && regAddr == `CMRP_ADR_BUSSF) busSf_ff <= regWrData;
      if (wrCmd && regWrData == `CMRP_CMD_ID11) idLong_ff <= 1'h0;
      if (wrCmd && regWrData == `CMRP_CMD_ID29) idLong_ff <= 1'h1;
    end
  end
  always_ff @(posedge clk) begin
    rdPend_ff <= reset_n && regRdEn;
    rdAddr_ff <= regAddr;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_rd_idle_zero: assert property (!rdPend_ff |-> regRdData == '0)
    else $error("read data not zero outside read cycle");
  chk_gstat_bits: assert property (
    rdPend_ff && rdAddr_ff == `CMRP_ADR_GSTAT |->
    regRdData == {29'h0, idLong_ff, $past(globalNewMessage), 1'h0})
    else $error("global status read wrong");
  chk_startup_enable: assert property (busStartup |=> primEnabled ==
    ($past(busSf_ff[2]) | $past(busSf_ff[3])) && expansionEnabled == !$past(busSf_ff[3]))
    else $error("start-up enables wrong");
  chk_enable_hold: assert property (!busStartup |=>
    $stable(primEnabled) && $stable(expansionEnabled))
    else $error("enables moved without start-up");
  chk_glob_rise_cause: assert property ($rose(globalNewMessage) |-> $past(frameSeen, 2))
    else $error("global flag rose without frame");
  chk_glob_fall_cause: assert property ($fell(globalNewMessage) |-> $past(wrCmd, 2))
    else $error("global flag fell without command");
  chk_fout_range: assert property (rdPend_ff && rdAddr_ff == `CMRP_ADR_FOUT |->
    regRdData == `CMRP_FIFO_EMPTY || regRdData < NUM_BOX)
    else $error("fifo output out of range");
  chk_fcnt_bound: assert property (rdPend_ff && rdAddr_ff == `CMRP_ADR_FCNT |->
    regRdData <= FIFO_DEPTH)
    else $error("fifo count above depth");
  chk_cmd_unmapped: assert property (rdPend_ff && (rdAddr_ff == `CMRP_ADR_CMD ||
    rdAddr_ff > `CMRP_ADR_DATA7) |-> regRdData == '0)
    else $error("command or unmapped read not zero");
  chk_bstat_upper: assert property (rdPend_ff && rdAddr_ff == `CMRP_ADR_BSTAT |->
    regRdData[31:3] == '0)
    else $error("box status reserved bits set");
  cover property (busStartup ##1 primEnabled);
  cover property ($rose(globalNewMessage));
  cover property ($fell(globalNewMessage));
endmodule

bind cmrp_mailbox_rx cmrp_mailbox_rx_asserts #(.NUM_BOX(NUM_BOX), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .clk, .reset_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .rxFrameValid, .rxId,
  .rxExtended, .rxByteCount, .rxData, .busStartup, .primEnabled, .expansionEnabled,
  .globalNewMessage);

// >>> cmrp_can_node.sv
`timescale 1ns/10ps
module cmrp_can_node (
  input  wire logic            clk,
  output logic                 rxFrameValid,
  output cmrp_pkg::cmrp_id_t   rxId,
  output logic                 rxExtended,
  output cmrp_pkg::cmrp_bcnt_t rxByteCount,
  output cmrp_pkg::cmrp_data_t rxData
);
  import cmrp_pkg::*;
  initial begin
    rxFrameValid = 1'h0;
    rxId = '1;
    rxExtended = 1'h1;
    rxByteCount = '1;
    rxData = '1;
  end
  // Fields invert between frames so stale values never pass for a frame
  task automatic quiet();
    rxFrameValid <= 1'h0;
    rxId <= ~rxId;
    rxExtended <= ~rxExtended;
    rxByteCount <= ~rxByteCount;
    rxData <= ~rxData;
  endtask
  // Only validly received frames reach the block; one cycle each
  task automatic send(input cmrp_id_t id, input logic ext, input cmrp_bcnt_t n,
                      input cmrp_data_t d);
    rxFrameValid <= 1'h1;
    rxId <= id;
    rxExtended <= ext;
    rxByteCount <= n;
    rxData <= d;
    @(posedge clk);
  endtask
endmodule

// >>> cmrp_mailbox_rx_tb.sv
`timescale 1ns/10ps
`include "cmrp_defs.svh"
module cmrp_mailbox_rx_tb;
  import cmrp_pkg::*;
  logic        clk, reset_n, regWrEn, regRdEn, busStartup, rdPend, rxFrameValid, rxExtended;
  logic        primEnabled, expansionEnabled, globalNewMessage;
  logic [15:0] regAddr;
  logic [31:0] regWrData, regRdData, seed, v;
  cmrp_id_t    rxId, longId;
  cmrp_bcnt_t  rxByteCount;
  cmrp_data_t  rxData, dat;
  logic [31:0] expQ[$];
  int          miscompares, n_compared, cycles;

  cmrp_mailbox_rx #(.NUM_BOX(32), .FIFO_DEPTH(32)) dut_u (.clk, .reset_n, .regAddr, .regWrData,
    .regWrEn, .regRdEn, .regRdData, .rxFrameValid, .rxId, .rxExtended, .rxByteCount, .rxData,
    .busStartup, .primEnabled, .expansionEnabled, .globalNewMessage);
  cmrp_can_node node_u (.clk, .rxFrameValid, .rxId, .rxExtended, .rxByteCount, .rxData);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Each strobe is set once per call, so back-to-back calls never double-drive
  task automatic bus(input logic [1:0] k, input logic [15:0] a, input logic [31:0] d);
    regWrEn <= k == 2'h1;
    regRdEn <= k == 2'h2;
    regAddr <= a;
    regWrData <= d;
    if (k == 2'h2) expQ.push_back(d);
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(2'h1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    bus(2'h2, a, e);
  endtask
  // Bus goes idle first so no stray read is issued during the frame
  task automatic frame(input cmrp_id_t id, input logic ext, input cmrp_bcnt_t n, cmrp_data_t d);
    regWrEn <= 1'h0;
    regRdEn <= 1'h0;
    node_u.send(id, ext, n, d);
    node_u.quiet();
    repeat (2) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(posedge clk) begin
    if (rdPend === 1'h1) check(regRdData, expQ.pop_front());
    rdPend <= regRdEn;
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    {reset_n, regWrEn, regRdEn, busStartup} = 4'h0;
    regAddr = 16'h0000;
    regWrData = 32'h0;
    seed = 32'h8C8A;
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    rd(`CMRP_ADR_FOUT, `CMRP_FIFO_EMPTY);
    rd(`CMRP_ADR_GSTAT, 32'h0);
    rd(`CMRP_ADR_BUSSF, `CMRP_RST_BUSSF);
    rd(16'h3000, 32'h0);
    wr(`CMRP_ADR_SEL, 32'h3);
    wr(`CMRP_ADR_DIR, 32'h0);
    wr(`CMRP_ADR_ID, 32'h123);
    wr(`CMRP_ADR_CMD, `CMRP_CMD_ACT);
    rd(`CMRP_ADR_BSTAT, 32'h1);
    frame(29'h123, 1'h0, 4'h5, 64'h0);
    rd(`CMRP_ADR_FCNT, 32'h0);
    for (int i = 0; i < 2; i++) begin
      v = i ? 32'h4 : 32'h8;
      wr(`CMRP_ADR_BUSSF, v);
      busStartup <= 1'h1;
      bus(2'h0, 16'h0000, 32'h0);
      busStartup <= 1'h0;
      bus(2'h0, 16'h0000, 32'h0);
      check({30'h0, expansionEnabled, primEnabled}, {30'h0, ~v[3], 1'h1});
    end
    dat = {$random(seed), $random(seed)};
    frame(29'h123, 1'h0, 4'h5, dat);
    rd(`CMRP_ADR_GSTAT, 32'h2);
    check({31'h0, globalNewMessage}, 32'h1);
    rd(`CMRP_ADR_FCNT, 32'h1);
    rd(`CMRP_ADR_FOUT, 32'h3);
    rd(`CMRP_ADR_FOUT, `CMRP_FIFO_EMPTY);
    wr(`CMRP_ADR_SEL, 32'h3);
    rd(`CMRP_ADR_BCNT, 32'h5);
    for (int k = 0; k < 8; k++) rd(`CMRP_ADR_DATA0 + 16'(k), {24'h0, dat[8*k+:8]});
    frame(29'h124, 1'h0, 4'h1, ~dat);
    frame(29'h123, 1'h0, 4'h2, ~dat);
    rd(`CMRP_ADR_BSTAT, 32'h7);
    rd(`CMRP_ADR_DATA0, {24'h0, dat[7:0]});
    rd(`CMRP_ADR_FCNT, 32'h0);
    wr(`CMRP_ADR_GSTAT, 32'h0);
    rd(`CMRP_ADR_GSTAT, 32'h2);
    wr(`CMRP_ADR_CMD, `CMRP_CMD_CLRNEW);
    bus(2'h0, 16'h0000, 32'h0);
    rd(`CMRP_ADR_GSTAT, 32'h0);
    check({31'h0, globalNewMessage}, 32'h0);
    rd(`CMRP_ADR_BSTAT, 32'h5);
    wr(`CMRP_ADR_CMD, `CMRP_CMD_CLROVR);
    rd(`CMRP_ADR_BSTAT, 32'h1);
    wr(`CMRP_ADR_MASK, 32'h7FF);
    wr(`CMRP_ADR_CODE, 32'h100);
    frame(29'h123, 1'h0, 4'h1, dat);
    rd(`CMRP_ADR_BSTAT, 32'h1);
    wr(`CMRP_ADR_CMD, `CMRP_CMD_ID11);
    frame(29'h123, 1'h0, 4'h1, dat);
    rd(`CMRP_ADR_BSTAT, 32'h3);
    wr(`CMRP_ADR_CMD, `CMRP_CMD_CLRFIFO);
    rd(`CMRP_ADR_FCNT, 32'h0);
    // Low bits match box 3, so a wrong 11-bit compare would pick it first
    longId = 29'h0ABCD123;
    wr(`CMRP_ADR_CMD, `CMRP_CMD_ID29);
    rd(`CMRP_ADR_GSTAT, 32'h6);
    wr(`CMRP_ADR_SEL, 32'h1F);
    wr(`CMRP_ADR_DIR, 32'h0);
    wr(`CMRP_ADR_ID, {3'h0, longId});
    wr(`CMRP_ADR_CMD, `CMRP_CMD_ACT);
    frame(longId ^ 29'h00100000, 1'h1, 4'h8, dat);
    frame(longId, 1'h0, 4'h8, dat);
    rd(`CMRP_ADR_FOUT, `CMRP_FIFO_EMPTY);
    frame(longId, 1'h1, 4'h8, dat);
    rd(`CMRP_ADR_FOUT, 32'h1F);
    rd(`CMRP_ADR_BSTAT, 32'h3);
    rd(`CMRP_ADR_BCNT, 32'h8);
    // Deactivated box must stop taking frames even with its flag cleared
    wr(`CMRP_ADR_CMD, `CMRP_CMD_DEACT);
    rd(`CMRP_ADR_BSTAT, 32'h2);
    wr(`CMRP_ADR_CMD, `CMRP_CMD_CLRNEW);
    frame(longId, 1'h1, 4'h2, ~dat);
    rd(`CMRP_ADR_BSTAT, 32'h0);
    wr(`CMRP_ADR_BCNT, 32'h3);
    wr(`CMRP_ADR_DATA0 + 16'h1, 32'hA5);
    rd(`CMRP_ADR_BCNT, 32'h3);
    rd(`CMRP_ADR_DATA0 + 16'h1, 32'hA5);
    repeat (2) bus(2'h0, 16'h0000, 32'h0);
    tally_and_finish();
  end
endmodule
